// ---- shared/spi_rx_status_pkg.sv ----
package spi_rx_status_pkg;

  // register byte offsets on the apb window
  localparam logic [11:0] status_off = 12'h000;
  localparam logic [11:0] config_off = 12'h010;
  localparam logic [11:0] irq_status_off = 12'h020;
  localparam logic [11:0] irq_clear_off = 12'h024;
  localparam logic [11:0] irq_enable_off = 12'h028;

  // serial_status_word field positions
  localparam int level_lsb = 8;
  localparam int level_msb = 10;
  localparam int ovf_bit = 7;
  localparam int tx_bit = 5;
  localparam int rx_bit = 3;

  // serial_config_word field positions
  localparam int flush_bit = 8;
  localparam int dir_bit = 6;

  // event index inside the flag vectors
  localparam int flag_count = 3;
  localparam int ev_ovf = 0;
  localparam int ev_rx = 1;
  localparam int ev_tx = 2;

  localparam logic [2:0] fifo_full_level = 3'h4;
  localparam logic [2:0] flags_reset = 3'h0;
  localparam logic [31:0] rdata_reset = 32'h0000_0000;

endpackage

// ---- shared/flag_event_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface flag_event_if;
  logic [spi_rx_status_pkg::flag_count-1:0] set;
  logic [spi_rx_status_pkg::flag_count-1:0] clr;
  logic [spi_rx_status_pkg::flag_count-1:0] flags;
  modport owner(output set, output clr, input flags);
  modport keeper(input set, input clr, output flags);
endinterface

`default_nettype wire

// ---- verilog/event_capture.sv ----
`timescale 1ns/1ps
`default_nettype none

module event_capture (
  input wire logic pclk,
  input wire logic presetn,
  flag_event_if.keeper ev
);

  typedef struct packed {
    logic [spi_rx_status_pkg::flag_count-1:0] flags;
  } cap_state_type;

  cap_state_type state_reg;
  cap_state_type state_next;

  // set wins over a clear in the same cycle
  always_comb begin
    state_next = state_reg;
    state_next.flags = (state_reg.flags & ~ev.clr) | ev.set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg.flags <= spi_rx_status_pkg::flags_reset;
    end else begin
      state_reg <= state_next;
    end
  end

  assign ev.flags = state_reg.flags;

  property p_set_wins;
    @(posedge pclk) disable iff (!presetn)
    (ev.set != 3'h0) |=> ((ev.flags & $past(ev.set)) == $past(ev.set));
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("flag set lost against clear");

endmodule

`default_nettype wire

// ---- verilog/spi_rx_status_flags.sv ----
// How it works
// - four bytes held reads level 100
// - push into full fifo sets overflow bit7
// - overflow interrupts unless receive flush set
// - rx flag bit3 when count reached, direction clear
// - status read clears overflow and rx flags
// - level field at bits 10:8, 000 empty
// - tx flag when direction set, read clears
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none

module spi_rx_status_flags (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] receive_fifo_level,
  input wire logic rx_push,
  input wire logic rx_count_done,
  input wire logic tx_count_done,
  output logic receive_flush_ctl,
  output logic irq_direction_select,
  output logic irq
);

  typedef struct packed {
    logic [31:0] rdata;
    logic flush;
    logic dir;
    logic [spi_rx_status_pkg::flag_count-1:0] irq_en;
  } top_state_type;

  top_state_type state_reg;
  top_state_type state_next;

  flag_event_if stat_ev();
  flag_event_if irq_ev();

  event_capture u_stat (
    .pclk(pclk),
    .presetn(presetn),
    .ev(stat_ev.keeper)
  );

  event_capture u_irq (
    .pclk(pclk),
    .presetn(presetn),
    .ev(irq_ev.keeper)
  );

  logic setup_phase;
  logic access_phase;
  logic status_read;
  logic mapped;
  logic [2:0] events;
  logic [15:0] status_word;

  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;
  assign mapped = (paddr == spi_rx_status_pkg::status_off)
    || (paddr == spi_rx_status_pkg::config_off)
    || (paddr == spi_rx_status_pkg::irq_status_off)
    || (paddr == spi_rx_status_pkg::irq_clear_off)
    || (paddr == spi_rx_status_pkg::irq_enable_off);
  assign status_read = access_phase && !pwrite
    && (paddr == spi_rx_status_pkg::status_off);

  assign pready = 1'b1;
  assign pslverr = access_phase && !mapped;

  // hardware events on the fifo side
  always_comb begin
    events = 3'h0;
    events[spi_rx_status_pkg::ev_ovf] = rx_push
      && (receive_fifo_level == spi_rx_status_pkg::fifo_full_level);
    events[spi_rx_status_pkg::ev_rx] = rx_count_done && !state_reg.dir;
    events[spi_rx_status_pkg::ev_tx] = tx_count_done && state_reg.dir;
  end

  // live view of the status word, reserved bits zero
  always_comb begin
    status_word = 16'h0000;
    status_word[spi_rx_status_pkg::level_msb:spi_rx_status_pkg::level_lsb] =
      receive_fifo_level;
    status_word[spi_rx_status_pkg::ovf_bit] =
      stat_ev.flags[spi_rx_status_pkg::ev_ovf];
    status_word[spi_rx_status_pkg::rx_bit] =
      stat_ev.flags[spi_rx_status_pkg::ev_rx];
    status_word[spi_rx_status_pkg::tx_bit] =
      stat_ev.flags[spi_rx_status_pkg::ev_tx];
  end

  assign stat_ev.set = events;
  // only flags already returned in prdata are cleared by the read
  assign stat_ev.clr = status_read ? {
    state_reg.rdata[spi_rx_status_pkg::tx_bit],
    state_reg.rdata[spi_rx_status_pkg::rx_bit],
    state_reg.rdata[spi_rx_status_pkg::ovf_bit]} : 3'h0;

  // overflow reaches the interrupt only with flushing off
  always_comb begin
    irq_ev.set = events;
    irq_ev.set[spi_rx_status_pkg::ev_ovf] =
      events[spi_rx_status_pkg::ev_ovf] && !state_reg.flush;
    irq_ev.clr = 3'h0;
    if (access_phase && pwrite
        && (paddr == spi_rx_status_pkg::irq_clear_off)) begin
      irq_ev.clr = pwdata[2:0];
    end
  end

  assign irq = |(irq_ev.flags & state_reg.irq_en);

  always_comb begin
    state_next = state_reg;
    if (setup_phase && !pwrite) begin
      if (paddr == spi_rx_status_pkg::status_off) begin
        state_next.rdata = {16'h0000, status_word};
      end else if (paddr == spi_rx_status_pkg::config_off) begin
        state_next.rdata = 32'h0000_0000;
        state_next.rdata[spi_rx_status_pkg::flush_bit] = state_reg.flush;
        state_next.rdata[spi_rx_status_pkg::dir_bit] = state_reg.dir;
      end else if (paddr == spi_rx_status_pkg::irq_status_off) begin
        state_next.rdata = {29'h0000_0000, irq_ev.flags};
      end else if (paddr == spi_rx_status_pkg::irq_enable_off) begin
        state_next.rdata = {29'h0000_0000, state_reg.irq_en};
      end else begin
        state_next.rdata = 32'h0000_0000;
      end
    end
    if (access_phase && pwrite) begin
      if (paddr == spi_rx_status_pkg::config_off) begin
        state_next.flush = pwdata[spi_rx_status_pkg::flush_bit];
        state_next.dir = pwdata[spi_rx_status_pkg::dir_bit];
      end else if (paddr == spi_rx_status_pkg::irq_enable_off) begin
        state_next.irq_en = pwdata[2:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg.rdata <= spi_rx_status_pkg::rdata_reset;
      state_reg.flush <= 1'b0;
      state_reg.dir <= 1'b0;
      state_reg.irq_en <= spi_rx_status_pkg::flags_reset;
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata = state_reg.rdata;
  assign receive_flush_ctl = state_reg.flush;
  assign irq_direction_select = state_reg.dir;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_setup_status;
    psel && !penable && !pwrite
      && (paddr == spi_rx_status_pkg::status_off);
  endsequence

  sequence s_access_status;
    psel && penable && !pwrite
      && (paddr == spi_rx_status_pkg::status_off);
  endsequence

  sequence s_overflow_push;
    rx_push && (receive_fifo_level == spi_rx_status_pkg::fifo_full_level);
  endsequence

  property p_level_four;
    s_setup_status ##0 (receive_fifo_level == 3'h4)
      |=> (prdata[10:8] == 3'b100);
  endproperty
  a_level_four: assert property (p_level_four)
    else $error("full fifo not read as 100");

  property p_level_field;
    s_setup_status |=> (prdata[10:8] == $past(receive_fifo_level));
  endproperty
  a_level_field: assert property (p_level_field)
    else $error("level field does not match fifo");

  property p_ovf_set;
    s_overflow_push |=> stat_ev.flags[0]
      && (irq_ev.flags[0] || $past(receive_flush_ctl));
  endproperty
  a_ovf_set: assert property (p_ovf_set)
    else $error("overflow flag not set on full push");

  property p_ovf_irq;
    s_overflow_push ##0 (!receive_flush_ctl && state_reg.irq_en[0]
      && !(psel && pwrite)) |=> irq;
  endproperty
  a_ovf_irq: assert property (p_ovf_irq)
    else $error("overflow did not raise interrupt");

  property p_flush_quiet;
    s_overflow_push ##0 (receive_flush_ctl && !irq_ev.flags[0]
      && !irq_ev.clr[0]) |=> !irq_ev.flags[0];
  endproperty
  a_flush_quiet: assert property (p_flush_quiet)
    else $error("overflow interrupt raised while flushing");

  property p_rx_set;
    rx_count_done && !irq_direction_select
      |=> stat_ev.flags[1] && irq_ev.flags[1];
  endproperty
  a_rx_set: assert property (p_rx_set)
    else $error("receive flag not set");

  property p_tx_set;
    tx_count_done && irq_direction_select |=> stat_ev.flags[2];
  endproperty
  a_tx_set: assert property (p_tx_set)
    else $error("transmit flag not set");

  property p_read_clears;
    s_setup_status ##0 (stat_ev.set == 3'h0)
      ##1 s_access_status ##0 (stat_ev.set == 3'h0)
      |=> (stat_ev.flags == 3'h0);
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("status read left a flag set");

  property p_reset_clear;
    $rose(presetn) |-> (stat_ev.flags == 3'h0) && !irq;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("flags not zero after reset");

endmodule

`default_nettype wire

// ---- dv/rx_fifo_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// receive fifo and byte counters of the serial engine, as seen by the flags
module rx_fifo_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] cmd,
  output logic [2:0] receive_fifo_level,
  output logic rx_push,
  output logic rx_count_done,
  output logic tx_count_done
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receive_fifo_level <= 3'h0;
      rx_push <= 1'b0;
      rx_count_done <= 1'b0;
      tx_count_done <= 1'b0;
    end else begin
      rx_push <= cmd[0];
      rx_count_done <= cmd[1];
      tx_count_done <= cmd[2];
      // a push into a full fifo is lost, the level stays at four
      if (rx_push && receive_fifo_level != 3'h4) begin
        receive_fifo_level <= receive_fifo_level + 3'h1;
      end
    end
  end
endmodule

`default_nettype wire

// ---- dv/spi_rx_status_flags_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module spi_rx_status_flags_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, flush, dir, irq;
  logic [2:0] cmd = 3'h0;
  logic [2:0] level;
  logic push, rx_done, tx_done;
  logic [31:0] rv;
  logic err;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;

  always #12.5 pclk = ~pclk;

  spi_rx_status_flags i_spi_rx_status_flags (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .receive_fifo_level(level), .rx_push(push), .rx_count_done(rx_done),
    .tx_count_done(tx_done), .receive_flush_ctl(flush),
    .irq_direction_select(dir), .irq(irq));

  rx_fifo_model i_rx_fifo_model (.pclk(pclk), .presetn(presetn), .cmd(cmd),
    .receive_fifo_level(level), .rx_push(push), .rx_count_done(rx_done),
    .tx_count_done(tx_done));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rv, exp);
  endtask

  // compare irq away from the edge that updates it
  task automatic irq_chk(input logic exp);
    @(negedge pclk);
    chk({31'h0000_0000, irq}, {31'h0000_0000, exp});
  endtask

  // one-cycle request to the fifo model, then let the flags settle
  task automatic ev(input logic [2:0] k);
    @(posedge pclk);
    cmd <= k;
    @(posedge pclk);
    cmd <= 3'h0;
    repeat (2) @(posedge pclk);
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles > 2000) begin
      fail_count++;
      give_verdict();
    end
  end

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(spi_rx_status_pkg::status_off, 32'h0000_0000);
    irq_chk(1'b0);
    apb(1'b1, spi_rx_status_pkg::irq_enable_off, 32'h0000_0007);
    repeat (4) ev(3'h1);
    rd_chk(spi_rx_status_pkg::status_off, 32'h0000_0400);
    ev(3'h1);
    rd_chk(spi_rx_status_pkg::status_off, 32'h0000_0480);
    rd_chk(spi_rx_status_pkg::irq_status_off, 32'h0000_0001);
    irq_chk(1'b1);
    rd_chk(spi_rx_status_pkg::status_off, 32'h0000_0400);
    apb(1'b1, spi_rx_status_pkg::irq_clear_off, 32'h0000_0001);
    irq_chk(1'b0);
    apb(1'b1, spi_rx_status_pkg::status_off, 32'h0000_ffff);
    rd_chk(spi_rx_status_pkg::status_off, 32'h0000_0400);
    // flush on: overflow is still flagged but raises no interrupt
    apb(1'b1, spi_rx_status_pkg::config_off, 32'h0000_0100);
    rd_chk(spi_rx_status_pkg::config_off, 32'h0000_0100);
    chk({31'h0000_0000, flush}, 32'h0000_0001);
    ev(3'h1);
    rd_chk(spi_rx_status_pkg::status_off, 32'h0000_0480);
    rd_chk(spi_rx_status_pkg::irq_status_off, 32'h0000_0000);
    irq_chk(1'b0);
    // direction clear: receive count flags, transmit count ignored
    apb(1'b1, spi_rx_status_pkg::config_off, 32'h0000_0000);
    ev(3'h2);
    ev(3'h4);
    rd_chk(spi_rx_status_pkg::status_off, 32'h0000_0408);
    rd_chk(spi_rx_status_pkg::irq_status_off, 32'h0000_0002);
    apb(1'b1, spi_rx_status_pkg::irq_clear_off, 32'h0000_0007);
    // direction set: transmit count flags, receive count ignored
    apb(1'b1, spi_rx_status_pkg::config_off, 32'h0000_0040);
    ev(3'h4);
    chk({31'h0000_0000, dir}, 32'h0000_0001);
    ev(3'h2);
    rd_chk(spi_rx_status_pkg::status_off, 32'h0000_0420);
    rd_chk(spi_rx_status_pkg::status_off, 32'h0000_0400);
    rd_chk(spi_rx_status_pkg::irq_status_off, 32'h0000_0004);
    irq_chk(1'b1);
    // second reset with flags pending: flags, config and irq drop to zero
    ev(3'h4);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(spi_rx_status_pkg::status_off, 32'h0000_0000);
    rd_chk(spi_rx_status_pkg::config_off, 32'h0000_0000);
    irq_chk(1'b0);
    rd_chk(12'h0fc, 32'h0000_0000);
    chk({31'h0000_0000, err}, 32'h0000_0001);
    give_verdict();
  end
endmodule

`default_nettype wire
